// ### rtl/p5g_port.sv
// port 5 pin control: mode, direction, data and pull-up registers
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`default_nettype none
module p5g_port
	import p5g_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire p5g_pkg::p5g_bus_t  bus,
	output var  logic [7:0]         rdata,
	input  wire logic [7:0]         pin_in,
	output var  p5g_pkg::p5g_pin_t  pins,
	input  wire logic               serial3_tx_sel,
	input  wire logic               serial3_txd,
	input  wire logic               serial_rx_on,
	output var  logic               serial3_rxd,
	output var  logic [5:0]         wake_in_n,
	output var  logic               converter_trigger_in
);
	import p5g_pkg::*;

	logic [7:0] mode_r;
	logic [7:0] dir_r;
	logic [7:0] data_r;
	logic [7:0] pull_r;
	p5g_pin_t   pins_nxt;
	logic [7:0] wake_sel;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic wr_hit(input p5g_bus_t b, input logic [1:0] a);
		return b.wr && (b.addr == a);
	endfunction : wr_hit

	function automatic logic [7:0] pin_read(input logic [7:0] dir, input logic [7:0] dat,
		input logic [7:0] pin);
		return (dir & dat) | (~dir & pin);
	endfunction : pin_read

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mode_r <= P5G_RST_VAL;
		else if (wr_hit(bus, P5G_ADDR_MODE))
			mode_r <= bus.wdata;
	end

	AST_MODE_LOAD: assert property (
		wr_hit(bus, P5G_ADDR_MODE) |=> mode_r == $past(bus.wdata))
		else $error("mode register write lost");
	AST_MODE_HOLD: assert property (
		!wr_hit(bus, P5G_ADDR_MODE) |=> $stable(mode_r))
		else $error("mode register changed without write");

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			dir_r <= P5G_RST_VAL;
		else if (wr_hit(bus, P5G_ADDR_DIR))
			dir_r <= bus.wdata;
	end

	AST_DIR_LOAD: assert property (
		wr_hit(bus, P5G_ADDR_DIR) |=> dir_r == $past(bus.wdata))
		else $error("direction register write lost");
	AST_DIR_HOLD: assert property (
		!wr_hit(bus, P5G_ADDR_DIR) |=> $stable(dir_r))
		else $error("direction register changed without write");

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			data_r <= P5G_RST_VAL;
		else if (wr_hit(bus, P5G_ADDR_DATA))
			data_r <= bus.wdata;
	end

	AST_DATA_LOAD: assert property (
		wr_hit(bus, P5G_ADDR_DATA) |=> data_r == $past(bus.wdata))
		else $error("data register write lost");
	AST_DATA_HOLD: assert property (
		!wr_hit(bus, P5G_ADDR_DATA) |=> $stable(data_r))
		else $error("data register changed without write");

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pull_r <= P5G_RST_VAL;
		else if (wr_hit(bus, P5G_ADDR_PULL))
			pull_r <= bus.wdata & P5G_PULL_MASK;
	end

	AST_PULL_LOAD: assert property (
		wr_hit(bus, P5G_ADDR_PULL) |=> pull_r == ($past(bus.wdata) & P5G_PULL_MASK))
		else $error("pull-up register write lost");
	AST_PULL_HOLD: assert property (
		!wr_hit(bus, P5G_ADDR_PULL) |=> $stable(pull_r))
		else $error("pull-up register changed without write");

	// ****************************************
	// read path
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= P5G_ZERO;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				P5G_ADDR_MODE: rdata <= mode_r;
				P5G_ADDR_DIR:  rdata <= P5G_ZERO;
				P5G_ADDR_DATA: rdata <= pin_read(dir_r, data_r, pin_in);
				P5G_ADDR_PULL: rdata <= pull_r & P5G_PULL_MASK;
			endcase
		end
		else
			rdata <= P5G_ZERO;
	end

	AST_MODE_RD: assert property (
		bus.rd && bus.addr == P5G_ADDR_MODE |=> rdata == $past(mode_r))
		else $error("mode register read wrong");
	AST_DATA_RD_OUT: assert property (
		bus.rd && bus.addr == P5G_ADDR_DATA |=>
		(rdata & $past(dir_r)) == ($past(data_r) & $past(dir_r)))
		else $error("output bits of data read wrong");
	AST_DATA_RD_IN: assert property (
		bus.rd && bus.addr == P5G_ADDR_DATA |=>
		(rdata & ~$past(dir_r)) == ($past(pin_in) & ~$past(dir_r)))
		else $error("input bits of data read wrong");
	AST_PULL_RD: assert property (
		bus.rd && bus.addr == P5G_ADDR_PULL |=> rdata == $past(pull_r))
		else $error("pull-up register read wrong");
	AST_PULL_RD_RSV: assert property (
		bus.rd && bus.addr == P5G_ADDR_PULL |=> rdata[P5G_W-1:P5G_OD6] == 2'h0)
		else $error("reserved pull-up bits read nonzero");

	// ****************************************
	// pin function select
	// ****************************************
	assign wake_sel = mode_r & P5G_WAKE_MASK;

	always_comb
	begin
		pins_nxt.o  = data_r;
		pins_nxt.oe = dir_r & ~wake_sel;
		pins_nxt.pu = pull_r & P5G_PULL_MASK & ~dir_r;
		if (mode_r[P5G_OD7])
		begin
			pins_nxt.o[P5G_OD7]  = 1'b0;
			pins_nxt.oe[P5G_OD7] = dir_r[P5G_OD7] & ~data_r[P5G_OD7];
		end
		if (mode_r[P5G_OD6])
		begin
			pins_nxt.o[P5G_OD6]  = 1'b0;
			pins_nxt.oe[P5G_OD6] = dir_r[P5G_OD6] & ~data_r[P5G_OD6];
		end
		if (serial3_tx_sel)
		begin
			pins_nxt.o[P5G_OD7]  = mode_r[P5G_OD7] ? 1'b0 : serial3_txd;
			pins_nxt.oe[P5G_OD7] = mode_r[P5G_OD7] ? ~serial3_txd : 1'b1;
		end
		if (serial_rx_on)
			pins_nxt.oe[P5G_OD6] = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pins <= '0;
		else
			pins <= pins_nxt;
	end

	AST_OE_GPIO: assert property (
		mode_r == P5G_ZERO && !serial3_tx_sel && !serial_rx_on |=> pins.oe == $past(dir_r))
		else $error("output enable does not follow direction");
	AST_O_GPIO: assert property (
		mode_r == P5G_ZERO && !serial3_tx_sel && !serial_rx_on |=> pins.o == $past(data_r))
		else $error("output value does not follow data");
	AST_O_LOW: assert property (
		##1 pins.o[P5G_TRIG:0] == $past(data_r[P5G_TRIG:0]))
		else $error("low pin outputs do not follow data");
	AST_WAKE_OE: assert property (
		##1 (pins.oe & $past(wake_sel)) == P5G_ZERO)
		else $error("wake pin still driven");
	AST_PU_DIR: assert property (
		##1 (pins.pu & $past(dir_r)) == P5G_ZERO)
		else $error("pull-up on an output pin");
	AST_PU_RSV: assert property (
		pins.pu[P5G_W-1:P5G_OD6] == 2'h0)
		else $error("pull-up on pin 7 or 6");
	AST_OE7_GPIO: assert property (
		!mode_r[P5G_OD7] && !serial3_tx_sel |=>
		pins.oe[P5G_OD7] == $past(dir_r[P5G_OD7]) && pins.o[P5G_OD7] == $past(data_r[P5G_OD7]))
		else $error("pin 7 general drive wrong");
	AST_OE6_GPIO: assert property (
		!mode_r[P5G_OD6] && !serial_rx_on |=>
		pins.oe[P5G_OD6] == $past(dir_r[P5G_OD6]) && pins.o[P5G_OD6] == $past(data_r[P5G_OD6]))
		else $error("pin 6 general drive wrong");
	AST_OD7_INPUT: assert property (
		mode_r[P5G_OD7] && !serial3_tx_sel && !dir_r[P5G_OD7] |=> !pins.oe[P5G_OD7])
		else $error("open-drain pin 7 driven while input");
	AST_OD6_INPUT: assert property (
		mode_r[P5G_OD6] && !serial_rx_on && !dir_r[P5G_OD6] |=> !pins.oe[P5G_OD6])
		else $error("open-drain pin 6 driven while input");
	AST_OD6_RELEASE: assert property (
		mode_r[P5G_OD6] && !serial_rx_on && data_r[P5G_OD6] |=> !pins.oe[P5G_OD6])
		else $error("open-drain pin 6 not released");
	AST_OD7_NO_HIGH: assert property (
		mode_r[P5G_OD7] |=> !pins.o[P5G_OD7])
		else $error("open-drain pin 7 drives high");
	AST_OD6_NO_HIGH: assert property (
		mode_r[P5G_OD6] |=> !pins.o[P5G_OD6])
		else $error("open-drain pin 6 drives high");
	AST_RX_RELEASE: assert property (
		serial_rx_on |=> !pins.oe[P5G_OD6])
		else $error("pin 6 driven while receiving");
	AST_TX_OD: assert property (
		serial3_tx_sel && mode_r[P5G_OD7] |=>
		pins.oe[P5G_OD7] == !$past(serial3_txd) && !pins.o[P5G_OD7])
		else $error("open-drain transmit on pin 7 wrong");

	// ****************************************
	// wake, trigger and serial receive inputs
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_in_n            <= '1;
			converter_trigger_in <= 1'b1;
			serial3_rxd          <= 1'b1;
		end
		else
		begin
			wake_in_n            <= pin_in[P5G_NWAKE-1:0] | ~wake_sel[P5G_NWAKE-1:0];
			converter_trigger_in <= pin_in[P5G_TRIG] | ~mode_r[P5G_TRIG];
			serial3_rxd          <= pin_in[P5G_OD6] | ~serial_rx_on;
		end
	end

	AST_WAKE_ON: assert property (
		##1 ((wake_in_n ^ $past(pin_in[P5G_NWAKE-1:0]))
		& $past(wake_sel[P5G_NWAKE-1:0])) == '0)
		else $error("wake input does not follow its pin");
	AST_WAKE_OFF: assert property (
		##1 (~wake_in_n & ~$past(wake_sel[P5G_NWAKE-1:0])) == '0)
		else $error("unselected wake input not idle");
	AST_TRIG_OFF: assert property (
		!mode_r[P5G_TRIG] |=> converter_trigger_in)
		else $error("trigger active while pin 5 is general");
	AST_TRIG_WAKE: assert property (
		mode_r[P5G_TRIG] |=> converter_trigger_in == wake_in_n[P5G_TRIG])
		else $error("trigger and wake 5 disagree");
	AST_RXD_ON: assert property (
		serial_rx_on |=> serial3_rxd == $past(pin_in[P5G_OD6]))
		else $error("receive data does not follow pin 6");
	AST_RXD_OFF: assert property (
		!serial_rx_on |=> serial3_rxd)
		else $error("receive data not idle");

	// ****************************************
	// assertions
	// ****************************************
	AST_OD7_LOW: assert property (
		mode_r[7] && !serial3_tx_sel && dir_r[7] && !data_r[7] |=> pins.oe[7] && !pins.o[7])
		else $error("pin 7 open-drain low not driven");
	AST_OD6_LOW: assert property (
		mode_r[6] && !serial_rx_on && dir_r[6] && !data_r[6] |=> pins.oe[6] && !pins.o[6])
		else $error("pin 6 open-drain low not driven");
	AST_OD_RELEASE: assert property (
		mode_r[7] && !serial3_tx_sel && data_r[7] |=> !pins.oe[7])
		else $error("open-drain pin 7 not released");
	AST_TRIG: assert property (
		mode_r[5] |=> !pins.oe[5] && converter_trigger_in == $past(pin_in[5]))
		else $error("pin 5 trigger routing wrong");
	AST_WAKE0: assert property (
		mode_r[0] |=> !pins.oe[0] && wake_in_n[0] == $past(pin_in[0]))
		else $error("pin 0 wake routing wrong");
	AST_MODE_WR: assert property (
		bus.wr && bus.addr == P5G_ADDR_MODE ##1 bus.rd && bus.addr == P5G_ADDR_MODE
		|=> rdata == $past(bus.wdata, 2))
		else $error("mode register readback wrong");
	AST_GPIO_OUT: assert property (
		!mode_r[1] && dir_r[1] |=> pins.oe[1] && pins.o[1] == $past(data_r[1]))
		else $error("pin 1 output drive wrong");
	AST_DIR_WO: assert property (
		bus.rd && bus.addr == P5G_ADDR_DIR |=> rdata == 8'h00)
		else $error("direction register not write-only");
	AST_DATA_RD: assert property (
		bus.rd && bus.addr == P5G_ADDR_DATA |=> rdata ==
		(($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(pin_in))))
		else $error("data read mux wrong");
	AST_PULL: assert property (
		##1 pins.pu == ($past(pull_r) & P5G_PULL_MASK & ~$past(dir_r)))
		else $error("pull-up gating wrong");
	AST_PULL_RSV: assert property (
		pull_r[7:6] == 2'h0)
		else $error("reserved pull-up bits set");
	AST_SER_TX: assert property (
		serial3_tx_sel && !mode_r[7] |=> pins.oe[7] && pins.o[7] == $past(serial3_txd))
		else $error("serial transmit not on pin 7");
endmodule : p5g_port
`default_nettype wire

// ### rtl/p5g_pkg.sv
// constants and types of the port 5 general-purpose pin block
// Contract
// - mode bit 7 set makes pin 7 an open-drain output, clear gives general I/O
// - mode bit 6 set makes pin 6 an open-drain output, clear gives general I/O
// - mode bit 5 set routes pin 5 to wake and trigger input
// - mode bits 4..0 set route their pins to wake inputs, ignoring direction
// - all mode bits readable, writable, reset to zero
// - general I/O pin: direction 1 drives output, 0 makes input
// - direction bits are write-only and reset to zero
// - data bits reset to zero and drive general I/O output pins
// - data read returns stored value where direction is 1
// - data read returns pin level where direction is 0
// - pull-up bits 5..0 enable pull-up only while direction bit clear
// - pull-up bits 7 and 6 read zero and ignore writes
`default_nettype none
package p5g_pkg;
	localparam int         P5G_W         = 8;
	localparam int         P5G_AW        = 2;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [1:0] P5G_ADDR_MODE = 2'h0;
	localparam logic [1:0] P5G_ADDR_DIR  = 2'h1;
	localparam logic [1:0] P5G_ADDR_DATA = 2'h2;
	localparam logic [1:0] P5G_ADDR_PULL = 2'h3;
	localparam logic [7:0] P5G_RST_VAL   = 8'h00;
	localparam logic [7:0] P5G_PULL_MASK = 8'h3F;
	localparam logic [7:0] P5G_WAKE_MASK = 8'h3F;
	localparam logic [7:0] P5G_ZERO      = 8'h00;
	localparam logic [7:0] P5G_ONES      = 8'hFF;
	localparam int         P5G_OD7       = 7;
	localparam int         P5G_OD6       = 6;
	localparam int         P5G_TRIG      = 5;
	localparam int         P5G_NWAKE     = 6;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [P5G_AW-1:0] addr;
		logic [P5G_W-1:0]  wdata;
	} p5g_bus_t;
	typedef struct packed {
		logic [P5G_W-1:0] o;
		logic [P5G_W-1:0] oe;
		logic [P5G_W-1:0] pu;
	} p5g_pin_t;
endpackage : p5g_pkg
`default_nettype wire

// ### testbench/p5g_board.sv
// board model: resolves each pin level from the block drive and an outside driver
`default_nettype none
module p5g_board
	import p5g_pkg::*;
(
	input  wire p5g_pkg::p5g_pin_t pins,
	input  wire logic [7:0]        ext,
	output wire logic [7:0]        pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven bits show the block value, others the outside level
	assign pin_in = (pins.oe & pins.o) | (~pins.oe & ext);
endmodule : p5g_board
`default_nettype wire

// ### testbench/test_p5g_port.sv
// self-checking bench of the port 5 pin block
`default_nettype none
module test_p5g_port
	import p5g_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 1'b0, rst_n = 1'b0, tx_sel = 1'b0, txd = 1'b0, rx_on = 1'b0, rxd, trig;
	p5g_bus_t   bus = '0;
	p5g_pin_t   pins;
	logic [7:0] rdata, pin_in, rv, m, d, t, p, e, ext = 8'h00;
	logic [5:0] wake_n;
	logic [31:0] seed = 32'h74E6;
	int         miscompares = 0, tests_run = 0;
	p5g_port p5g_port_i (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.pin_in(pin_in), .pins(pins), .serial3_tx_sel(tx_sel), .serial3_txd(txd),
		.serial_rx_on(rx_on), .serial3_rxd(rxd), .wake_in_n(wake_n),
		.converter_trigger_in(trig));
	p5g_board p5g_board_i (.pins(pins), .ext(ext), .pin_in(pin_in));
	initial forever #4 mclk = ~mclk;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	function automatic logic [7:0] rd_exp(logic [7:0] dr, dt, lv);
		return (dr & dt) | (~dr & lv);
	endfunction : rd_exp
	task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(logic [1:0] a, logic [7:0] v);
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, a, v};
	endtask : wr
	task automatic rd(logic [1:0] a, output logic [7:0] v);
		@(posedge mclk);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk);
		bus <= '0;
		#1 v = rdata;
	endtask : rd
	task automatic settle();
		@(posedge mclk);
		bus <= '0;
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	initial
	begin
		#200000;
		miscompares++;
		give_verdict();
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 0; a < 4; a++)
		begin
			rd(a[1:0], rv);
			chk("reset value", rv, 8'h00);
		end
		wr(P5G_ADDR_PULL, 8'hFF);
		rd(P5G_ADDR_PULL, rv);
		chk("pull reserved", rv, 8'h3F);
		for (int i = 0; i < 24; i++)
		begin
			m = xs();
			d = (i == 0) ? 8'hFF : xs();
			t = xs();
			p = xs();
			e = xs();
			wr(P5G_ADDR_MODE, m);
			rd(P5G_ADDR_MODE, rv);
			chk("mode", rv, m);
			wr(P5G_ADDR_MODE, 8'h00);
			wr(P5G_ADDR_DIR, d);
			wr(P5G_ADDR_DATA, t);
			wr(P5G_ADDR_PULL, p);
			ext <= e;
			settle();
			chk("oe", pins.oe, d);
			chk("out", pins.o & d, t & d);
			chk("pu", pins.pu, p & 8'h3F & ~d);
			rd(P5G_ADDR_DATA, rv);
			chk("data read", rv, rd_exp(d, t, e));
			rd(P5G_ADDR_DIR, rv);
			chk("dir read", rv, 8'h00);
			wr(P5G_ADDR_MODE, 8'h3F);
			settle();
			chk("wake oe", pins.oe, d & 8'hC0);
			chk("wake", {2'b00, wake_n}, {2'b00, e[5:0]});
			chk("trig", {7'h00, trig}, {7'h00, e[5]});
			rd(P5G_ADDR_DATA, rv);
			chk("wake data read", rv, rd_exp(d, t, e));
		end
		wr(P5G_ADDR_MODE, 8'hC0);
		wr(P5G_ADDR_DIR, 8'hC0);
		wr(P5G_ADDR_DATA, 8'h40);
		settle();
		chk("open drain", {pins.oe[7:6], pins.o[7], 5'h00}, 8'h80);
		wr(P5G_ADDR_MODE, 8'h00);
		tx_sel <= 1'b1;
		txd <= 1'b1;
		rx_on <= 1'b1;
		ext <= 8'h00;
		settle();
		chk("serial", {pins.oe[7:6], pins.o[7], rxd, 4'h0}, 8'hA0);
		give_verdict();
	end
endmodule : test_p5g_port
`default_nettype wire
